/* include/bwss_map.vh */
// register map and field constants for the bridge window and secondary status bank
`ifndef BWSS_MAP_VH
`define BWSS_MAP_VH

`define BWSS_ADDR_W          8
`define BWSS_OFS_IO_WIN      8'h1c
`define BWSS_OFS_MEM_WIN     8'h20
`define BWSS_OFS_IO_UPPER    8'h30
`define BWSS_OFS_CTRL        8'h40
`define BWSS_OFS_IRQ_STAT    8'h44
`define BWSS_OFS_IRQ_MASK    8'h48

`define BWSS_IO_ADDR_IND     4'h1
`define BWSS_IO_FLD_RST      4'h0
`define BWSS_MEM_FLD_RST     12'h000
`define BWSS_UPPER_RST       16'h0000
`define BWSS_IO_LOW_ZERO     12'h000
`define BWSS_IO_LOW_ONES     12'hfff
`define BWSS_MEM_LOW_ZERO    20'h00000
`define BWSS_MEM_LOW_ONES    20'hfffff
`define BWSS_NIB_ZERO        4'h0
`define BWSS_RSVD5_ZERO      5'h00

`define BWSS_CTRL_PERR_EN    0
`define BWSS_CTRL_SERR_EN    1
`define BWSS_CTRL_W          2
`define BWSS_CTRL_RST        2'h0
`define BWSS_CTRL_FLD        1:0
`define BWSS_WORD_ZERO       32'h00000000

`define BWSS_IO_BASE_FLD     7:4
`define BWSS_IO_LIM_FLD      15:12
`define BWSS_MEM_BASE_FLD    15:4
`define BWSS_MEM_LIM_FLD     31:20
`define BWSS_UP_LO_FLD       15:0
`define BWSS_UP_HI_FLD       31:16
`define BWSS_ST_PERR_BIT     24
`define BWSS_ST_SYS_BIT      30
`define BWSS_ST_POISON_BIT   31

`define BWSS_EV_W            7
`define BWSS_EV_PERR         0
`define BWSS_EV_SIG_CA       1
`define BWSS_EV_RX_CA        2
`define BWSS_EV_RX_UR        3
`define BWSS_EV_SYS_ERR      4
`define BWSS_EV_POISON       5
`define BWSS_EV_RSVD         6
`define BWSS_EV_RST          7'h00

`endif

/* rtl/bwss_regs.v */
// bridge window and secondary status register bank with avalon-mm slave
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "bwss_map.vh"

module bwss_regs
(
    input  wire                    sys_clk_i,
    input  wire                    srst_i,
    input  wire [`BWSS_ADDR_W-1:0] avs_address_i,
    input  wire                    avs_read_i,
    input  wire                    avs_write_i,
    input  wire [31:0]             avs_writedata_i,
    input  wire [3:0]              avs_byteenable_i,
    output wire [31:0]             avs_readdata_o,
    output wire                    avs_waitrequest_o,
    input  wire                    sec_parity_err_i,
    input  wire                    sec_cpl_abort_sent_i,
    input  wire                    sec_rx_cpl_abort_i,
    input  wire                    sec_rx_unsup_req_i,
    input  wire                    err_msg_sent_i,
    input  wire                    sec_rx_poisoned_i,
    input  wire [31:0]             io_addr_i,
    input  wire [31:0]             mem_addr_i,
    output wire                    io_fwd_o,
    output wire                    mem_fwd_o,
    output wire                    irq_o
);

    reg         wait_reg;
    reg         wait_next;
    reg  [31:0] rdata_reg;
    reg  [31:0] rdata_next;
    reg  [3:0]  io_base_reg;
    reg  [3:0]  io_base_next;
    reg  [3:0]  io_lim_reg;
    reg  [3:0]  io_lim_next;
    reg  [15:0] io_base_up_reg;
    reg  [15:0] io_base_up_next;
    reg  [15:0] io_lim_up_reg;
    reg  [15:0] io_lim_up_next;
    reg  [11:0] mem_base_reg;
    reg  [11:0] mem_base_next;
    reg  [11:0] mem_lim_reg;
    reg  [11:0] mem_lim_next;
    reg  [1:0]  ctrl_reg;
    reg  [1:0]  ctrl_next;
    reg         st_perr_reg;
    reg         st_perr_next;
    reg         st_sig_ca_reg;
    reg         st_sig_ca_next;
    reg         st_rx_ca_reg;
    reg         st_rx_ca_next;
    reg         st_rx_ur_reg;
    reg         st_rx_ur_next;
    reg         st_sys_reg;
    reg         st_sys_next;
    reg         st_poison_reg;
    reg         st_poison_next;
    reg  [`BWSS_EV_W-1:0] irq_stat_reg;
    reg  [`BWSS_EV_W-1:0] irq_stat_next;
    reg  [`BWSS_EV_W-1:0] irq_mask_reg;
    reg  [`BWSS_EV_W-1:0] irq_mask_next;
    reg         irq_reg;
    reg         io_fwd_reg;
    reg         mem_fwd_reg;

    wire        req;
    wire        commit;
    wire        wr;
    wire [31:0] wmask;
    wire [31:0] wdat;
    wire [15:0] sec_status;
    wire [31:0] io_win_word;
    wire [31:0] mem_win_word;
    wire [31:0] io_bottom;
    wire [31:0] io_top;
    wire [31:0] mem_bottom;
    wire [31:0] mem_top;
    wire        set_perr;
    wire        set_sys;
    wire [`BWSS_EV_W-1:0] ev;

    // readback, window and clear-strobe helpers
    wire [31:0] io_up_word;
    wire [31:0] ctrl_word;
    wire [31:0] irq_stat_word;
    wire [31:0] irq_mask_word;
    wire        io_hit;
    wire        mem_hit;
    wire        st_wr;
    wire        irq_stat_wr;

    assign req    = avs_read_i | avs_write_i;
    assign commit = req & ~wait_reg;
    assign wr     = commit & avs_write_i;
    assign wmask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                     {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign wdat   = avs_writedata_i & wmask;

    // legacy bus bits and reserved bits tied low
    assign sec_status = {st_poison_reg, st_sys_reg, st_rx_ur_reg, st_rx_ca_reg,
                         st_sig_ca_reg, 2'b00, st_perr_reg, 1'b0, 1'b0, 1'b0,
                         `BWSS_RSVD5_ZERO};

    assign io_win_word  = {sec_status, io_lim_reg, `BWSS_IO_ADDR_IND,
                           io_base_reg, `BWSS_IO_ADDR_IND};
    assign mem_win_word = {mem_lim_reg, `BWSS_NIB_ZERO, mem_base_reg, `BWSS_NIB_ZERO};

    assign io_bottom  = {io_base_up_reg, io_base_reg, `BWSS_IO_LOW_ZERO};
    assign io_top     = {io_lim_up_reg, io_lim_reg, `BWSS_IO_LOW_ONES};
    assign mem_bottom = {mem_base_reg, `BWSS_MEM_LOW_ZERO};
    assign mem_top    = {mem_lim_reg, `BWSS_MEM_LOW_ONES};

    assign set_perr = sec_parity_err_i & ctrl_reg[`BWSS_CTRL_PERR_EN];
    assign set_sys  = err_msg_sent_i & ctrl_reg[`BWSS_CTRL_SERR_EN];

    // irq status follows the gated events
    assign ev = {1'b0, sec_rx_poisoned_i, set_sys, sec_rx_unsup_req_i,
                 sec_rx_cpl_abort_i, sec_cpl_abort_sent_i, set_perr};

    // readback words, unused bits read zero
    assign io_up_word    = {io_lim_up_reg, io_base_up_reg};
    assign ctrl_word     = {{(32-`BWSS_CTRL_W){1'b0}}, ctrl_reg};
    assign irq_stat_word = {{(32-`BWSS_EV_W){1'b0}}, irq_stat_reg};
    assign irq_mask_word = {{(32-`BWSS_EV_W){1'b0}}, irq_mask_reg};

    // inclusive compare, a base above its limit never hits
    assign io_hit  = (io_addr_i >= io_bottom) && (io_addr_i <= io_top);
    assign mem_hit = (mem_addr_i >= mem_bottom) && (mem_addr_i <= mem_top);

    // one-to-clear strobes, only on a committed write
    assign st_wr       = wr && (avs_address_i == `BWSS_OFS_IO_WIN) && avs_byteenable_i[3];
    assign irq_stat_wr = wr && (avs_address_i == `BWSS_OFS_IRQ_STAT) && avs_byteenable_i[0];

    // bus handshake: one wait cycle, then the access commits
    always @*
    begin
        wait_next  = ~(req & wait_reg);
        rdata_next = rdata_reg;
        if (req & wait_reg & avs_read_i)
        begin
            case (avs_address_i)
                `BWSS_OFS_IO_WIN:   rdata_next = io_win_word;
                `BWSS_OFS_MEM_WIN:  rdata_next = mem_win_word;
                `BWSS_OFS_IO_UPPER: rdata_next = io_up_word;
                `BWSS_OFS_CTRL:     rdata_next = ctrl_word;
                `BWSS_OFS_IRQ_STAT: rdata_next = irq_stat_word;
                `BWSS_OFS_IRQ_MASK: rdata_next = irq_mask_word;
                default:            rdata_next = `BWSS_WORD_ZERO;
            endcase
        end
    end

    // writable window and control fields
    always @*
    begin
        io_base_next    = io_base_reg;
        io_lim_next     = io_lim_reg;
        io_base_up_next = io_base_up_reg;
        io_lim_up_next  = io_lim_up_reg;
        mem_base_next   = mem_base_reg;
        mem_lim_next    = mem_lim_reg;
        ctrl_next       = ctrl_reg;
        irq_mask_next   = irq_mask_reg;
        if (wr)
        begin
            case (avs_address_i)
                `BWSS_OFS_IO_WIN:
                begin
                    if (avs_byteenable_i[0])
                    begin
                        io_base_next = avs_writedata_i[`BWSS_IO_BASE_FLD];
                    end
                    if (avs_byteenable_i[1])
                    begin
                        io_lim_next = avs_writedata_i[`BWSS_IO_LIM_FLD];
                    end
                end
                `BWSS_OFS_MEM_WIN:
                begin
                    mem_base_next = (mem_base_reg & ~wmask[`BWSS_MEM_BASE_FLD])
                                    | wdat[`BWSS_MEM_BASE_FLD];
                    mem_lim_next  = (mem_lim_reg & ~wmask[`BWSS_MEM_LIM_FLD])
                                    | wdat[`BWSS_MEM_LIM_FLD];
                end
                `BWSS_OFS_IO_UPPER:
                begin
                    io_base_up_next = (io_base_up_reg & ~wmask[`BWSS_UP_LO_FLD])
                                      | wdat[`BWSS_UP_LO_FLD];
                    io_lim_up_next  = (io_lim_up_reg & ~wmask[`BWSS_UP_HI_FLD])
                                      | wdat[`BWSS_UP_HI_FLD];
                end
                `BWSS_OFS_CTRL:
                begin
                    if (avs_byteenable_i[0])
                    begin
                        ctrl_next = avs_writedata_i[`BWSS_CTRL_FLD];
                    end
                end
                `BWSS_OFS_IRQ_MASK:
                begin
                    if (avs_byteenable_i[0])
                    begin
                        irq_mask_next = avs_writedata_i[`BWSS_EV_W-1:0];
                    end
                end
                default:
                begin
                    ctrl_next = ctrl_reg;
                end
            endcase
        end
    end

    // sticky status, set wins over a clear in the same cycle
    always @*
    begin
        st_perr_next   = st_perr_reg | set_perr;
        st_sig_ca_next = st_sig_ca_reg | sec_cpl_abort_sent_i;
        st_rx_ca_next  = st_rx_ca_reg | sec_rx_cpl_abort_i;
        st_rx_ur_next  = st_rx_ur_reg | sec_rx_unsup_req_i;
        st_sys_next    = st_sys_reg | set_sys;
        st_poison_next = st_poison_reg | sec_rx_poisoned_i;
        irq_stat_next  = irq_stat_reg | ev;
        // the abort and unsupported bits have no software clear
        if (st_wr)
        begin
            st_perr_next   = (st_perr_reg & ~avs_writedata_i[`BWSS_ST_PERR_BIT])
                             | set_perr;
            st_sys_next    = (st_sys_reg & ~avs_writedata_i[`BWSS_ST_SYS_BIT])
                             | set_sys;
            st_poison_next = (st_poison_reg & ~avs_writedata_i[`BWSS_ST_POISON_BIT])
                             | sec_rx_poisoned_i;
        end
        if (irq_stat_wr)
        begin
            irq_stat_next = (irq_stat_reg & ~avs_writedata_i[`BWSS_EV_W-1:0]) | ev;
        end
    end

    // bus handshake and read data
    always @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            wait_reg  <= 1'b1;
            rdata_reg <= `BWSS_WORD_ZERO;
        end
        else
        begin
            wait_reg  <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    // window and control fields
    always @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            io_base_reg    <= `BWSS_IO_FLD_RST;
            io_lim_reg     <= `BWSS_IO_FLD_RST;
            io_base_up_reg <= `BWSS_UPPER_RST;
            io_lim_up_reg  <= `BWSS_UPPER_RST;
            mem_base_reg   <= `BWSS_MEM_FLD_RST;
            mem_lim_reg    <= `BWSS_MEM_FLD_RST;
            ctrl_reg       <= `BWSS_CTRL_RST;
        end
        else
        begin
            io_base_reg    <= io_base_next;
            io_lim_reg     <= io_lim_next;
            io_base_up_reg <= io_base_up_next;
            io_lim_up_reg  <= io_lim_up_next;
            mem_base_reg   <= mem_base_next;
            mem_lim_reg    <= mem_lim_next;
            ctrl_reg       <= ctrl_next;
        end
    end

    // sticky status, interrupt status, mask and level
    always @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            st_perr_reg    <= 1'b0;
            st_sig_ca_reg  <= 1'b0;
            st_rx_ca_reg   <= 1'b0;
            st_rx_ur_reg   <= 1'b0;
            st_sys_reg     <= 1'b0;
            st_poison_reg  <= 1'b0;
            irq_stat_reg   <= `BWSS_EV_RST;
            irq_mask_reg   <= `BWSS_EV_RST;
            irq_reg        <= 1'b0;
        end
        else
        begin
            st_perr_reg    <= st_perr_next;
            st_sig_ca_reg  <= st_sig_ca_next;
            st_rx_ca_reg   <= st_rx_ca_next;
            st_rx_ur_reg   <= st_rx_ur_next;
            st_sys_reg     <= st_sys_next;
            st_poison_reg  <= st_poison_next;
            irq_stat_reg   <= irq_stat_next;
            irq_mask_reg   <= irq_mask_next;
            irq_reg        <= |(irq_stat_next & irq_mask_next);
        end
    end

    // forward decisions, one cycle behind the address
    always @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            io_fwd_reg  <= 1'b0;
            mem_fwd_reg <= 1'b0;
        end
        else
        begin
            io_fwd_reg  <= io_hit;
            mem_fwd_reg <= mem_hit;
        end
    end

    assign avs_readdata_o    = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign io_fwd_o          = io_fwd_reg;
    assign mem_fwd_o         = mem_fwd_reg;
    assign irq_o             = irq_reg;

endmodule // bwss_regs

`default_nettype wire

/* verif/bwss_regs_checker.sv */
// concurrent checks on the bridge window and secondary status bank ports
`timescale 1ns/1ps
`default_nettype none
module bwss_regs_checker
(
    input wire logic        sys_clk_i,
    input wire logic        srst_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        io_fwd_o,
    input wire logic        mem_fwd_o,
    input wire logic        irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    sequence rd_ack(logic [7:0] a);
        avs_read_i && !avs_waitrequest_o && avs_address_i == a;
    endsequence
    sequence req_wait;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    wait_one_a: assert property (req_wait |=> !avs_waitrequest_o)
        else $error("waitrequest did not drop one cycle after a request");
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    idle_wait_a: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
        else $error("waitrequest low without a request");
    ind_read_a: assert property (rd_ack(8'h1c) |-> avs_readdata_o[11:8] == 4'h1)
        else $error("i/o addressing indicator not one");
    legacy_zero_a: assert property (rd_ack(8'h1c) |-> avs_readdata_o[26:16] == {2'h0, 9'h000
        } || (avs_readdata_o[26:25] == 2'h0 && avs_readdata_o[23:16] == 8'h00))
        else $error("legacy or reserved status bits not zero");
    mem_rsvd_a: assert property (rd_ack(8'h20) |-> avs_readdata_o[3:0] == 4'h0)
        else $error("reserved memory base bits not zero");
    unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o && !(avs_address_i
        inside {8'h1c, 8'h20, 8'h30, 8'h40, 8'h44, 8'h48}) |-> avs_readdata_o == 32'h0)
        else $error("unmapped read returned nonzero data");
    reset_quiet_a: assert property (@(posedge sys_clk_i) disable iff (1'b0) srst_i |=>
        avs_waitrequest_o && !irq_o && !io_fwd_o && !mem_fwd_o && avs_readdata_o == 32'h0)
        else $error("outputs not quiet after reset");
endmodule // bwss_regs_checker
`default_nettype wire

/* verif/bridge_window_and_secondary_status_test.sv */
// self-checking bench for the bridge window and secondary status bank
`timescale 1ns/1ps
`default_nettype none
module bridge_window_and_secondary_status_test;
    logic        sys_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0, wr = 1'b0;
    logic [31:0] wdat = 32'h0, io_a = 32'h0, mem_a = 32'h0, rdat;
    logic [3:0]  be = 4'hf;
    logic [5:0]  ev = 6'h00, st = 6'h00;
    logic [6:0]  ist = 7'h00;
    logic        wreq, io_f, mem_f, irq;
    int          miscompares = 0, comparisons = 0;
    logic [31:0] m [6] = '{default: 32'h0};
    logic [7:0]  ofs [6] = '{8'h1c, 8'h20, 8'h30, 8'h40, 8'h44, 8'h48};
    logic [31:0] msk [6] = '{32'hf0f0, 32'hfff0fff0, 32'hffffffff, 32'h3, 32'h0, 32'h7f};
    bwss_regs DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .sec_parity_err_i(ev[0]),
        .sec_cpl_abort_sent_i(ev[1]), .sec_rx_cpl_abort_i(ev[2]), .sec_rx_unsup_req_i(ev[3]),
        .err_msg_sent_i(ev[4]), .sec_rx_poisoned_i(ev[5]), .io_addr_i(io_a),
        .mem_addr_i(mem_a), .io_fwd_o(io_f), .mem_fwd_o(mem_f), .irq_o(irq));
    task automatic summarize;
        $display("counts: comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(string n, logic e, logic g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] b,
        output logic [31:0] q);
        int n;
        adr <= a; wdat <= d; be <= b; wr <= w; rd <= !w;
        n = 0;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end
        while (wreq !== 1'b0 && n < 20);
        q = rdat;
        rd <= 1'b0; wr <= 1'b0;
        if (wreq !== 1'b0)
        begin
            miscompares++;
            summarize();
        end
        @(posedge sys_clk_i);
    endtask
    task automatic wr_m(int i, logic [31:0] d, logic [3:0] b);
        logic [31:0] q, bm;
        bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        bus(1'b1, ofs[i], d, b, q);
        m[i] = (m[i] & ~bm) | (d & bm & msk[i]);
        if (i == 0 && b[3]) st = st & ~{d[31], d[30], 3'b000, d[24]};
        if (i == 4 && b[0]) ist = ist & ~d[6:0];
    endtask
    function automatic logic [31:0] exp_word(int i);
        exp_word = m[i];
        if (i == 0) exp_word = exp_word | 32'h0101 | {st[5:1], 2'b00, st[0], 24'h0};
        if (i == 4) exp_word = {25'h0, ist};
    endfunction
    function automatic logic [31:0] lo(logic mem);
        lo = mem ? {m[1][15:4], 20'h00000} : {m[2][15:0], m[0][7:4], 12'h000};
    endfunction
    function automatic logic [31:0] hi(logic mem);
        hi = mem ? {m[1][31:20], 20'hfffff} : {m[2][31:16], m[0][15:12], 12'hfff};
    endfunction
    function automatic logic [31:0] pick(logic mem, int k);
        pick = (k % 4 == 0) ? lo(mem) : (k % 4 == 1) ? hi(mem) : (k % 4 == 2) ? lo(mem) - 1 :
            hi(mem) + 1;
    endfunction
    task automatic check_regs(int i);
        logic [31:0] q;
        bus(1'b0, ofs[i], 32'h0, 4'hf, q);
        chk_word("register", exp_word(i), q);
    endtask
    task automatic pulse(int i);
        ev <= 6'h01 << i;
        @(posedge sys_clk_i);
        ev <= 6'h00;
        if ((i != 0 && i != 4) || m[3][i / 4]) {st[i], ist[i]} = 2'b11;
        repeat (2) @(posedge sys_clk_i);
        chk_bit("irq", |(ist & m[5][6:0]), irq);
    endtask
    initial
    begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    initial
    begin
        logic [31:0] q;
        int i, k;
        void'($urandom(99241));
        repeat (6) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        for (k = 0; k < 30; k++)
        begin
            i = (k < 6) ? k : $urandom_range(5);
            if (k >= 6) wr_m(i, $urandom, 4'($urandom_range(15)));
            check_regs(i);
        end
        bus(1'b1, 8'h24, 32'hffffffff, 4'hf, q);
        bus(1'b0, 8'h24, 32'h0, 4'hf, q);
        chk_word("unmapped", 32'h0, q);
        $display("test registers done");
        for (k = 0; k < 48; k++)
        begin
            if (k % 8 == 0)
            begin
                wr_m(0, $urandom, 4'h3);
                wr_m(1, $urandom, 4'hf);
                wr_m(2, $urandom & 32'h00010001, 4'hf);
            end
            io_a <= (k < 40) ? pick(1'b0, k) : $urandom;
            mem_a <= (k < 40) ? pick(1'b1, k) : $urandom;
            repeat (2) @(posedge sys_clk_i);
            chk_bit("io_fwd", io_a >= lo(1'b0) && io_a <= hi(1'b0), io_f);
            chk_bit("mem_fwd", mem_a >= lo(1'b1) && mem_a <= hi(1'b1), mem_f);
        end
        $display("test windows done");
        wr_m(5, 32'h7f, 4'hf);
        for (k = 0; k < 12; k++)
        begin
            if (k % 6 == 0) wr_m(3, (k < 6) ? 32'h0 : 32'h3, 4'hf);
            pulse(k % 6);
            check_regs(0);
            check_regs(4);
        end
        wr_m(0, 32'hffff0000, 4'h8);
        check_regs(0);
        wr_m(4, 32'h7f, 4'h1);
        check_regs(4);
        wr_m(5, 32'h0, 4'hf);
        pulse(5);
        wr_m(5, 32'h20, 4'hf);
        repeat (2) @(posedge sys_clk_i);
        chk_bit("irq unmasked", 1'b1, irq);
        $display("test events done");
        summarize();
    end
endmodule // bridge_window_and_secondary_status_test
bind bwss_regs bwss_regs_checker u_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .io_fwd_o(io_fwd_o), .mem_fwd_o(mem_fwd_o), .irq_o(irq_o));
`default_nettype wire
